// [rau_pkg.sv]
// Constants for the RAM/ROM addressing unit: register map, fields, commands.
// Assumes a 32-bit AXI4-Lite register bus and a 10-bit program ROM word.
package rau_pkg;

  // ****************************************************************
  // Widths
  // ****************************************************************
  localparam int RAU_PC_W   = 14;
  localparam int RAU_RAM_W  = 10;
  localparam int RAU_ROM_W  = 10;
  localparam int RAU_NIB_W  = 4;
  localparam int RAU_AXI_AW = 8;

  // ****************************************************************
  // Register byte addresses (bank select is register index 0x3F)
  // ****************************************************************
  localparam logic [7:0] RAU_IDX_BANK_SEL = 8'h3F;
  localparam logic [RAU_AXI_AW-1:0] RAU_ADDR_CMD      = 8'h00;
  localparam logic [RAU_AXI_AW-1:0] RAU_ADDR_INDEX    = 8'h04;
  localparam logic [RAU_AXI_AW-1:0] RAU_ADDR_ACC      = 8'h08;
  localparam logic [RAU_AXI_AW-1:0] RAU_ADDR_PAIR     = 8'h0C;
  localparam logic [RAU_AXI_AW-1:0] RAU_ADDR_PC       = 8'h10;
  localparam logic [RAU_AXI_AW-1:0] RAU_ADDR_RAM      = 8'h14;
  localparam logic [RAU_AXI_AW-1:0] RAU_ADDR_PORTS    = 8'h18;
  localparam logic [RAU_AXI_AW-1:0] RAU_ADDR_BANK_SEL = 8'hFC; // 4 x index

  // ****************************************************************
  // Command register fields
  // ****************************************************************
  localparam int RAU_CMD_OP_LSB  = 0;
  localparam int RAU_CMD_IMM_LSB = 4;

  localparam logic [3:0] RAU_OP_NONE       = 4'h0;
  localparam logic [3:0] RAU_OP_LONG_JUMP  = 4'h1;
  localparam logic [3:0] RAU_OP_LONG_BRNCH = 4'h2;
  localparam logic [3:0] RAU_OP_CALL       = 4'h3;
  localparam logic [3:0] RAU_OP_SHORT_PAGE = 4'h4;
  localparam logic [3:0] RAU_OP_ZERO_CALL  = 4'h5;
  localparam logic [3:0] RAU_OP_TABLE_JUMP = 4'h6;
  localparam logic [3:0] RAU_OP_TABLE_READ = 4'h7;
  localparam logic [3:0] RAU_OP_ADVANCE    = 4'h8;
  localparam logic [3:0] RAU_OP_RAM_DIRECT = 4'h9;
  localparam logic [3:0] RAU_OP_RAM_INDIR  = 4'hA;
  localparam logic [3:0] RAU_OP_RAM_MEMREG = 4'hB;

  // ****************************************************************
  // RAM address forming modes
  // ****************************************************************
  localparam logic [1:0] RAU_RM_INDIRECT = 2'h0;
  localparam logic [1:0] RAU_RM_DIRECT   = 2'h1;
  localparam logic [1:0] RAU_RM_MEMREG   = 2'h2;

  localparam logic [RAU_RAM_W-1:0] RAU_BANK_LO   = 10'h090;
  localparam logic [RAU_RAM_W-1:0] RAU_BANK_HI   = 10'h25F;
  localparam logic [RAU_RAM_W-1:0] RAU_MEMREG_LO = 10'h040;

  // ****************************************************************
  // ROM word fields, page layout, reset values, bus answers
  // ****************************************************************
  localparam int RAU_ROM_ACC_BIT  = 8;
  localparam int RAU_ROM_PORT_BIT = 9;
  localparam logic [7:0] RAU_PAGE_LAST = 8'hFF;
  localparam logic [RAU_PC_W-1:0] RAU_PC_RST = 14'h0000;
  localparam logic [3:0] RAU_NIB_RST = 4'h0;
  localparam logic [1:0] RAU_RESP_OKAY   = 2'h0;
  localparam logic [1:0] RAU_RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    RAU_ST_IDLE  = 2'b00,
    RAU_ST_FETCH = 2'b01,
    RAU_ST_APPLY = 2'b10
  } rau_state_t;

endpackage

// [rau_ram_addr.sv]
// RAM address former for the addressing unit: indirect, direct, memory register.
// Assumes load is a one-cycle pulse from the main module in the aclk domain.
`timescale 1ns/10ps
module rau_ram_addr
  import rau_pkg::*;
(
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  input  wire logic                 ce,
  input  wire logic                 load,
  input  wire logic [1:0]           mode,
  input  wire logic [RAU_RAM_W-1:0] index,
  input  wire logic [RAU_RAM_W-1:0] imm,
  input  wire logic [RAU_NIB_W-1:0] bank_sel,
  output logic      [RAU_RAM_W-1:0] ram_addr,
  output logic                      bank_hit,
  output logic      [RAU_NIB_W-1:0] ram_bank
);

  logic [RAU_RAM_W-1:0] next_ram_addr;
  logic                 next_bank_hit;
  logic [RAU_NIB_W-1:0] next_ram_bank;
  logic [RAU_RAM_W-1:0] addr_sel;

  // ****************************************************************
  // Address selection and bank qualification
  // ****************************************************************
  always_comb
  begin
    addr_sel      = index;
    if (mode == RAU_RM_DIRECT)
    begin
      addr_sel = imm;
    end
    else if (mode == RAU_RM_MEMREG)
    begin
      addr_sel = RAU_MEMREG_LO | {6'h00, imm[3:0]};
    end
    next_ram_addr = ram_addr;
    next_bank_hit = bank_hit;
    next_ram_bank = ram_bank;
    if (load)
    begin
      next_ram_addr = addr_sel;
      // Bank only matters inside the banked window
      next_bank_hit = (addr_sel >= RAU_BANK_LO) && (addr_sel <= RAU_BANK_HI);
      next_ram_bank = next_bank_hit ? bank_sel : RAU_NIB_RST;
    end
  end

  // Register the formed address
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ram_addr <= 10'h000;
      bank_hit <= 1'b0;
      ram_bank <= RAU_NIB_RST;
    end
    else if (ce)
    begin
      ram_addr <= next_ram_addr;
      bank_hit <= next_bank_hit;
      ram_bank <= next_ram_bank;
    end
  end

endmodule // rau_ram_addr

// [rau_top.sv]
// Addressing unit top: AXI4-Lite registers, program counter forming, table read.
// Assumes the program ROM returns rom_data one cycle after rom_rd is high.
`timescale 1ns/10ps

// Operation
// - Indirect RAM addressing uses the single ten-bit index register as the address.
// - RAM addresses 0x090 to 0x25F are qualified by the bank select.
// - Direct RAM addressing uses the ten-bit second word as address.
// - Sixteen memory registers sit at RAM 0x040 to 0x04F.
// - Long jump, long branch and call load all fourteen counter bits from the immediate.
// - ROM has 64 pages of 256 words and a short page jump replaces the low eight bits.
// - A short page jump at the last word of a page lands in the following page.
// - Zero-page call loads six bits into bits 5..0 and clears bits 13..6.
// - A table jump target joins a four-bit immediate, the accumulator and pair.
// - A table-read word with bit 8 set loads its low byte into accumulator and pair.
// - A table-read word with bit 9 set loads its low byte into both port latches.
// - With bits 8 and 9 both set, all four destinations update together.
// - A table read only advances the program counter to the next instruction.
module rau_top
  import rau_pkg::*;
(
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic                  ce,
  input  wire logic [RAU_AXI_AW-1:0] s_axi_awaddr,
  input  wire logic [2:0]            s_axi_awprot,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [RAU_AXI_AW-1:0] s_axi_araddr,
  input  wire logic [2:0]            s_axi_arprot,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  output logic [RAU_PC_W-1:0]        rom_addr,
  output logic                       rom_rd,
  input  wire logic [RAU_ROM_W-1:0]  rom_data,
  output logic [RAU_RAM_W-1:0]       ram_addr,
  output logic                       ram_bank_hit,
  output logic [RAU_NIB_W-1:0]       ram_bank,
  output logic [RAU_NIB_W-1:0]       port_one_latch,
  output logic [RAU_NIB_W-1:0]       port_two_latch
);

  // ****************************************************************
  // State
  // ****************************************************************
  logic                  aw_held,   next_aw_held;
  logic [RAU_AXI_AW-1:0] aw_addr,   next_aw_addr;
  logic                  w_held,    next_w_held;
  logic [31:0]           w_data,    next_w_data;
  logic [3:0]            w_strb,    next_w_strb;
  logic                  bvalid,    next_bvalid;
  logic [1:0]            bresp,     next_bresp;
  logic                  rvalid,    next_rvalid;
  logic [31:0]           rdata,     next_rdata;
  logic [1:0]            rresp,     next_rresp;
  logic [RAU_PC_W-1:0]   pc,        next_pc;
  logic [RAU_RAM_W-1:0]  index,     next_index;
  logic [RAU_NIB_W-1:0]  acc,       next_acc;
  logic [RAU_NIB_W-1:0]  pair,      next_pair;
  logic [RAU_NIB_W-1:0]  ram_bank_select, next_ram_bank_select;
  logic [RAU_NIB_W-1:0]  port_one,  next_port_one;
  logic [RAU_NIB_W-1:0]  port_two,  next_port_two;
  logic [RAU_PC_W-1:0]   rom_addr_q, next_rom_addr_q;
  rau_state_t            state,     next_state;
  logic                  ram_load,  next_ram_load;
  logic [1:0]            ram_mode,  next_ram_mode;
  logic [RAU_RAM_W-1:0]  ram_imm,   next_ram_imm;

  logic                  do_write;
  logic                  wr_ok;
  logic [31:0]           merged;
  logic [3:0]            cmd_op;
  logic [RAU_PC_W-1:0]   cmd_imm;
  logic [RAU_PC_W-1:0]   table_addr;
  logic [5:0]            page_sel;
  logic [31:0]           rd_word;
  logic                  rd_ok;

  // Byte-lane merge of a write into an existing word
  function automatic logic [31:0] rau_merge(input logic [31:0] old_w,
                                            input logic [31:0] new_w,
                                            input logic [3:0]  strb);
    logic [31:0] res;
    res = old_w;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
      begin
        res[i*8 +: 8] = new_w[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // ****************************************************************
  // Bus handshakes
  // ****************************************************************
  // One write in flight: readies stay low until the response is taken
  assign s_axi_awready = !aw_held && !bvalid;
  assign s_axi_wready  = !w_held && !bvalid;
  assign s_axi_arready = !rvalid;
  assign s_axi_bvalid  = bvalid;
  assign s_axi_bresp   = bresp;
  assign s_axi_rvalid  = rvalid;
  assign s_axi_rdata   = rdata;
  assign s_axi_rresp   = rresp;
  assign do_write      = aw_held && w_held && !bvalid;

  // Outputs of the datapath
  assign rom_addr       = rom_addr_q;
  assign rom_rd         = (state == RAU_ST_FETCH);
  assign port_one_latch = port_one;
  assign port_two_latch = port_two;

  // Command fields and the shared table address
  assign cmd_op     = w_data[RAU_CMD_OP_LSB +: 4];
  assign cmd_imm    = w_data[RAU_CMD_IMM_LSB +: RAU_PC_W];
  assign table_addr = {cmd_imm[3:0], 2'b00, acc, pair};
  // A short page jump from the last word of a page lands on the next page
  assign page_sel   = (pc[7:0] == RAU_PAGE_LAST) ? pc[13:8] + 6'h01 : pc[13:8];

  // ****************************************************************
  // Read decode
  // ****************************************************************
  always_comb
  begin
    rd_word = 32'h0000_0000;
    rd_ok   = 1'b1;
    if (s_axi_araddr == RAU_ADDR_CMD)
    begin
      rd_word = 32'(state != RAU_ST_IDLE);
    end
    else if (s_axi_araddr == RAU_ADDR_INDEX)
    begin
      rd_word = 32'(index);
    end
    else if (s_axi_araddr == RAU_ADDR_ACC)
    begin
      rd_word = 32'(acc);
    end
    else if (s_axi_araddr == RAU_ADDR_PAIR)
    begin
      rd_word = 32'(pair);
    end
    else if (s_axi_araddr == RAU_ADDR_PC)
    begin
      rd_word = 32'(pc);
    end
    else if (s_axi_araddr == RAU_ADDR_RAM)
    begin
      rd_word = 32'({ram_bank_hit, 2'b00, ram_bank, ram_addr});
    end
    else if (s_axi_araddr == RAU_ADDR_PORTS)
    begin
      rd_word = 32'({port_two, port_one});
    end
    else if (s_axi_araddr == RAU_ADDR_BANK_SEL)
    begin
      rd_word = 32'(ram_bank_select);
    end
    else
    begin
      rd_ok = 1'b0;
    end
  end

  // ****************************************************************
  // Next-state logic for bus, registers and operations
  // ****************************************************************
  always_comb
  begin
    next_aw_held = aw_held;
    next_aw_addr = aw_addr;
    next_w_held  = w_held;
    next_w_data  = w_data;
    next_w_strb  = w_strb;
    next_bvalid  = bvalid;
    next_bresp   = bresp;
    next_rvalid  = rvalid;
    next_rdata   = rdata;
    next_rresp   = rresp;
    next_pc      = pc;
    next_index   = index;
    next_acc     = acc;
    next_pair    = pair;
    next_ram_bank_select = ram_bank_select;
    next_port_one = port_one;
    next_port_two = port_two;
    next_rom_addr_q = rom_addr_q;
    next_state    = state;
    next_ram_load = 1'b0;
    next_ram_mode = ram_mode;
    next_ram_imm  = ram_imm;
    wr_ok  = 1'b1;
    merged = 32'h0000_0000;

    // Address and data are accepted in either order
    if (s_axi_awvalid && s_axi_awready)
    begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (bvalid && s_axi_bready)
    begin
      next_bvalid = 1'b0;
    end

    // Table read sequence: fetch, then route the word by its flag bits
    case (state)
      RAU_ST_FETCH:
      begin
        next_state = RAU_ST_APPLY;
      end
      RAU_ST_APPLY:
      begin
        if (rom_data[RAU_ROM_ACC_BIT])
        begin
          next_acc  = rom_data[3:0];
          next_pair = rom_data[7:4];
        end
        if (rom_data[RAU_ROM_PORT_BIT])
        begin
          next_port_one = rom_data[3:0];
          next_port_two = rom_data[7:4];
        end
        // Neither bit set: all four destinations keep their value
        next_state = RAU_ST_IDLE;
      end
      default:
      begin
        next_state = RAU_ST_IDLE;
      end
    endcase

    // Register write; a command during a table read is dropped
    if (do_write)
    begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      if (aw_addr == RAU_ADDR_CMD)
      begin
        if (state == RAU_ST_IDLE && w_strb == 4'hF)
        begin
          case (cmd_op)
            RAU_OP_LONG_JUMP, RAU_OP_LONG_BRNCH, RAU_OP_CALL:
            begin
              next_pc = cmd_imm;
            end
            RAU_OP_SHORT_PAGE:
            begin
              next_pc = {page_sel, cmd_imm[7:0]};
            end
            RAU_OP_ZERO_CALL:
            begin
              next_pc = {8'h00, cmd_imm[5:0]};
            end
            RAU_OP_TABLE_JUMP:
            begin
              next_pc = table_addr;
            end
            RAU_OP_TABLE_READ:
            begin
              next_rom_addr_q = table_addr;
              next_pc    = pc + 14'h0001;
              next_state = RAU_ST_FETCH;
            end
            RAU_OP_ADVANCE:
            begin
              next_pc = pc + 14'h0001;
            end
            RAU_OP_RAM_DIRECT:
            begin
              next_ram_load = 1'b1;
              next_ram_mode = RAU_RM_DIRECT;
              next_ram_imm  = cmd_imm[RAU_RAM_W-1:0];
            end
            RAU_OP_RAM_INDIR:
            begin
              next_ram_load = 1'b1;
              next_ram_mode = RAU_RM_INDIRECT;
            end
            RAU_OP_RAM_MEMREG:
            begin
              next_ram_load = 1'b1;
              next_ram_mode = RAU_RM_MEMREG;
              next_ram_imm  = cmd_imm[RAU_RAM_W-1:0];
            end
            default:
            begin
              next_ram_load = 1'b0;
            end
          endcase
        end
      end
      else if (aw_addr == RAU_ADDR_INDEX)
      begin
        merged     = rau_merge(32'(index), w_data, w_strb);
        next_index = merged[RAU_RAM_W-1:0];
      end
      else if (aw_addr == RAU_ADDR_ACC)
      begin
        merged   = rau_merge(32'(acc), w_data, w_strb);
        next_acc = merged[3:0];
      end
      else if (aw_addr == RAU_ADDR_PAIR)
      begin
        merged    = rau_merge(32'(pair), w_data, w_strb);
        next_pair = merged[3:0];
      end
      else if (aw_addr == RAU_ADDR_PC)
      begin
        merged  = rau_merge(32'(pc), w_data, w_strb);
        next_pc = merged[RAU_PC_W-1:0];
      end
      else if (aw_addr == RAU_ADDR_PORTS)
      begin
        merged        = rau_merge(32'({port_two, port_one}), w_data, w_strb);
        next_port_one = merged[3:0];
        next_port_two = merged[7:4];
      end
      else if (aw_addr == RAU_ADDR_BANK_SEL)
      begin
        merged = rau_merge(32'(ram_bank_select), w_data, w_strb);
        next_ram_bank_select = merged[3:0];
      end
      else if (aw_addr != RAU_ADDR_RAM)
      begin
        wr_ok = 1'b0;
      end
      next_bresp = wr_ok ? RAU_RESP_OKAY : RAU_RESP_SLVERR;
    end

    // Reads answer one cycle after the address is taken
    if (rvalid && s_axi_rready)
    begin
      next_rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready)
    begin
      next_rvalid = 1'b1;
      next_rdata  = rd_word;
      next_rresp  = rd_ok ? RAU_RESP_OKAY : RAU_RESP_SLVERR;
    end
  end

  // Register everything; ce low freezes the whole block
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held <= 1'b0;
      aw_addr <= 8'h00;
      w_held  <= 1'b0;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
      bvalid  <= 1'b0;
      bresp   <= RAU_RESP_OKAY;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= RAU_RESP_OKAY;
      pc      <= RAU_PC_RST;
      index   <= 10'h000;
      acc     <= RAU_NIB_RST;
      pair    <= RAU_NIB_RST;
      ram_bank_select <= RAU_NIB_RST;
      port_one   <= RAU_NIB_RST;
      port_two   <= RAU_NIB_RST;
      rom_addr_q <= RAU_PC_RST;
      state      <= RAU_ST_IDLE;
      ram_load   <= 1'b0;
      ram_mode   <= RAU_RM_INDIRECT;
      ram_imm    <= 10'h000;
    end
    else if (ce)
    begin
      aw_held <= next_aw_held;
      aw_addr <= next_aw_addr;
      w_held  <= next_w_held;
      w_data  <= next_w_data;
      w_strb  <= next_w_strb;
      bvalid  <= next_bvalid;
      bresp   <= next_bresp;
      rvalid  <= next_rvalid;
      rdata   <= next_rdata;
      rresp   <= next_rresp;
      pc      <= next_pc;
      index   <= next_index;
      acc     <= next_acc;
      pair    <= next_pair;
      ram_bank_select <= next_ram_bank_select;
      port_one   <= next_port_one;
      port_two   <= next_port_two;
      rom_addr_q <= next_rom_addr_q;
      state      <= next_state;
      ram_load   <= next_ram_load;
      ram_mode   <= next_ram_mode;
      ram_imm    <= next_ram_imm;
    end
  end

  // ****************************************************************
  // RAM address former
  // ****************************************************************
  rau_ram_addr u_ram_addr (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .ce       (ce),
    .load     (ram_load),
    .mode     (ram_mode),
    .index    (index),
    .imm      (ram_imm),
    .bank_sel (ram_bank_select),
    .ram_addr (ram_addr),
    .bank_hit (ram_bank_hit),
    .ram_bank (ram_bank)
  );

endmodule // rau_top

// [rau_rom_model.sv]
// Program ROM model for the table-read path of rau_top.
// Assumes a one-cycle read latency after rom_rd, on aclk.
`timescale 1ns/10ps
module rau_rom_model
  import rau_pkg::*;
(
  input  wire logic                 aclk,
  input  wire logic                 rom_rd,
  input  wire logic [RAU_PC_W-1:0]  rom_addr,
  output logic      [RAU_ROM_W-1:0] rom_data
);
  // Data follow the address; they invert off the answer cycle so stale data fail
  initial rom_data = 10'h000;
  always @(posedge aclk)
    if (rom_rd)
      rom_data <= {rom_addr[1:0], rom_addr[7:0] ^ 8'hA5};
    else
      rom_data <= ~rom_data;
endmodule // rau_rom_model

// [rau_top_monitor.sv]
// Port checker for rau_top, bound into every instance.
// Assumes ce is held high and no register write overlaps a table read.
`timescale 1ns/10ps
module rau_top_monitor
  import rau_pkg::*;
(
  input wire logic                 aclk,
  input wire logic                 aresetn,
  input wire logic                 s_axi_awready,
  input wire logic                 s_axi_wready,
  input wire logic                 s_axi_bvalid,
  input wire logic                 s_axi_arvalid,
  input wire logic                 s_axi_arready,
  input wire logic                 s_axi_rvalid,
  input wire logic [1:0]           s_axi_rresp,
  input wire logic                 rom_rd,
  input wire logic [RAU_PC_W-1:0]  rom_addr,
  input wire logic [RAU_ROM_W-1:0] rom_data,
  input wire logic [RAU_RAM_W-1:0] ram_addr,
  input wire logic                 ram_bank_hit,
  input wire logic [RAU_NIB_W-1:0] ram_bank,
  input wire logic [RAU_NIB_W-1:0] port_one_latch,
  input wire logic [RAU_NIB_W-1:0] port_two_latch
);
  // ****************************************************************
  // Properties
  // ****************************************************************
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_rom_one_shot: assert property (rom_rd |=> !rom_rd)
    else $error("rom read longer than one cycle");
  a_table_form: assert property (rom_rd |-> rom_addr[9:8] == 2'b00)
    else $error("table address gap bits set");
  a_port_load: assert property (rom_rd ##1 rom_data[9] |=>
    port_one_latch == $past(rom_data[3:0]) && port_two_latch == $past(rom_data[7:4]))
    else $error("port latches not loaded");
  a_port_keep: assert property (rom_rd ##1 !rom_data[9] |=>
    $stable(port_one_latch) && $stable(port_two_latch))
    else $error("port latches changed");
  a_bank_range: assert property (ram_bank_hit ==
    (ram_addr >= RAU_BANK_LO && ram_addr <= RAU_BANK_HI))
    else $error("bank hit wrong");
  a_bank_off: assert property (!ram_bank_hit |-> ram_bank == 4'h0)
    else $error("bank shown outside area");
  a_write_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answer pending");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  c_both_flags: cover property (rom_rd ##1 rom_data[8] && rom_data[9]);
  c_bank_hit: cover property (ram_bank_hit);
  c_read_err: cover property (s_axi_rvalid && s_axi_rresp == RAU_RESP_SLVERR);
endmodule // rau_top_monitor

bind rau_top rau_top_monitor rau_top_monitor_inst (.*);

// [rau_top_test.sv]
// Self-checking bench for rau_top: bus, jumps, table read, RAM modes.
// Assumes rau_rom_model answers one cycle after rom_rd.
`timescale 1ns/10ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_errors++; \
  $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module rau_top_test
  import rau_pkg::*;
;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, awready, wready;
  logic bvalid, arready, rvalid, rom_rd, ah, wh, b;
  logic [1:0] bresp, rresp, br;
  logic [7:0] awaddr, araddr, d8;
  logic [31:0] wdata, rdata;
  logic [13:0] rom_addr, i;
  logic [9:0] rom_data, x;
  logic [3:0] a, p, bs;
  logic [65:0] e, q[$];
  int n_errors, n_checks, k;

  rau_top rau_top_inst (.aclk, .aresetn, .ce(1'b1),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .rom_addr, .rom_rd,
    .rom_data, .ram_addr(), .ram_bank_hit(), .ram_bank(),
    .port_one_latch(), .port_two_latch());
  rau_rom_model rau_rom_model_inst (.aclk, .rom_rd, .rom_addr, .rom_data);

  // ****************************************************************
  // Bus tasks; ready is sampled mid-cycle, where it has settled
  // ****************************************************************
  function automatic logic [31:0] cmd(input logic [3:0] o, input logic [13:0] m);
    return {14'h0, m, o};
  endfunction
  function automatic logic [31:0] st(input logic [9:0] r);
    logic h;
    h = r >= RAU_BANK_LO && r <= RAU_BANK_HI;
    return {15'h0, h, 2'b00, h ? bs : 4'h0, r};
  endfunction
  task automatic wr(input logic [7:0] ad, input logic [31:0] d, input logic [1:0] er = 2'h0);
    awaddr <= ad;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(negedge aclk);
      ah = awvalid && awready;
      wh = wvalid && wready;
      b = bvalid;
      br = bresp;
      @(posedge aclk);
      if (ah) awvalid <= 1'b0;
      if (wh) wvalid <= 1'b0;
    end while (!b);
    `CHK(br, er)
  endtask
  task automatic rd(input logic [7:0] ad, input logic [31:0] d, input logic [1:0] er = 2'h0,
                    input logic [31:0] m = 32'hFFFFFFFF);
    q.push_back({m, er, d});
    araddr <= ad;
    arvalid <= 1'b1;
    do begin
      @(negedge aclk);
      ah = arvalid && arready;
      b = rvalid;
      @(posedge aclk);
      if (ah) arvalid <= 1'b0;
    end while (!b);
  endtask
  task automatic end_sim;
    n_errors += q.size();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Answer watcher: oldest note against each read answer
  always @(negedge aclk)
    if (rvalid && rready && q.size() > 0)
    begin
      e = q.pop_front();
      `CHK({rresp, rdata & e[65:34]}, {e[33:32], e[31:0] & e[65:34]})
    end

  // Clock and watchdog
  initial
  begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  initial
  begin
    #50000;
    n_errors++;
    end_sim();
  end

  // Tests
  initial
  begin
    {aresetn, awvalid, wvalid, arvalid, awaddr, araddr, wdata} = '0;
    {bready, rready} = 2'b11;
    void'($urandom(60));
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(RAU_ADDR_PC, 32'h0);
    rd(8'h40, 32'h0, RAU_RESP_SLVERR, 32'h0);
    wr(8'h40, 32'h0, RAU_RESP_SLVERR);
    $display("test reset done");
    for (k = 0; k < 3; k++)
    begin
      i = 14'($urandom) & 14'h3FFE;
      wr(RAU_ADDR_CMD, cmd(4'(RAU_OP_LONG_JUMP + k), i));
      rd(RAU_ADDR_PC, 32'(i));
      d8 = 8'($urandom);
      wr(RAU_ADDR_CMD, cmd(RAU_OP_SHORT_PAGE, 14'(d8)));
      rd(RAU_ADDR_PC, 32'({i[13:8], d8}));
    end
    wr(RAU_ADDR_CMD, cmd(RAU_OP_LONG_JUMP, 14'h12FF));
    wr(RAU_ADDR_CMD, cmd(RAU_OP_SHORT_PAGE, 14'h0042));
    rd(RAU_ADDR_PC, 32'h1342);
    i = 14'($urandom);
    wr(RAU_ADDR_CMD, cmd(RAU_OP_ZERO_CALL, i));
    rd(RAU_ADDR_PC, 32'(i[5:0]));
    a = 4'($urandom);
    p = 4'($urandom);
    wr(RAU_ADDR_ACC, 32'(a));
    wr(RAU_ADDR_PAIR, 32'(p));
    wr(RAU_ADDR_CMD, cmd(RAU_OP_TABLE_JUMP, i));
    rd(RAU_ADDR_PC, 32'({i[3:0], 2'b00, a, p}));
    $display("test jumps done");
    // Pair low bits select which destinations the fetched word hits
    for (k = 0; k < 4; k++)
    begin
      i = 14'($urandom);
      a = 4'($urandom);
      p = {2'($urandom), 2'(k)};
      x = 10'($urandom);
      d8 = {a, p} ^ 8'hA5;
      wr(RAU_ADDR_CMD, cmd(RAU_OP_LONG_JUMP, i));
      wr(RAU_ADDR_ACC, 32'(a));
      wr(RAU_ADDR_PAIR, 32'(p));
      wr(RAU_ADDR_PORTS, 32'(x[7:0]));
      wr(RAU_ADDR_CMD, cmd(RAU_OP_TABLE_READ, 14'h0));
      rd(RAU_ADDR_PC, 32'(14'(i + 14'h1)));
      rd(RAU_ADDR_ACC, 32'(k[0] ? d8[3:0] : a));
      rd(RAU_ADDR_PAIR, 32'(k[0] ? d8[7:4] : p));
      rd(RAU_ADDR_PORTS, 32'(k[1] ? d8 : x[7:0]));
    end
    $display("test table read done");
    bs = 4'($urandom);
    wr(RAU_ADDR_BANK_SEL, 32'(bs));
    for (k = 0; k < 5; k++)
    begin
      x = k == 0 ? 10'h08F : k == 1 ? 10'h090 : k == 2 ? 10'h25F : k == 3 ? 10'h260 : 10'($urandom);
      wr(RAU_ADDR_CMD, cmd(RAU_OP_RAM_DIRECT, 14'(x)));
      rd(RAU_ADDR_RAM, st(x));
    end
    x = 10'($urandom);
    wr(RAU_ADDR_INDEX, 32'(x));
    wr(RAU_ADDR_CMD, cmd(RAU_OP_RAM_INDIR, 14'h0));
    rd(RAU_ADDR_RAM, st(x));
    wr(RAU_ADDR_CMD, cmd(RAU_OP_RAM_MEMREG, i));
    rd(RAU_ADDR_RAM, st(10'h040 | 10'(i[3:0])));
    $display("test ram done");
    repeat (4) @(posedge aclk);
    end_sim();
  end
endmodule // rau_top_test
